// *** spi_unit_cfg.svh ***
// Constants for the serial peripheral unit
`ifndef SPI_UNIT_CFG_SVH
`define SPI_UNIT_CFG_SVH
`define DIVISOR_W 8
`define DATA_W 8
`define DIVISOR_ONE 8'h01
`define TX_EMPTY_RESET 1'b1
`define SCLK_IDLE_RESET 1'b0
`endif

// *** spi_unit_pkg.sv ***
// Types shared by the serial peripheral unit
package spi_unit_pkg;
  typedef struct packed {
    logic [7:0] serial_clock_divisor0;
    logic [7:0] serial_clock_divisor1;
    logic clock_polarity_select;
    logic clock_phase_select;
    logic keep_select_after_transfer0;
    logic mode_fault_disable;
    logic master_mode;
    logic active_select;
  } spi_cfg_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE = 3'b100
  } mst_state_t;
endpackage

// *** spi_unit.sv ***
// Master/slave serial peripheral unit with its documented quirks
// Functional notes
// RL1: No transmit underrun flag in slave mode
// RL2: Mixed divisor one, polarity one: extra clock pulse
// RL3: Software keeps divisors all one in that case
// RL4: Slave enable may raise false receive ready
// RL5: Software toggles polarity then reads holding register
// RL6: Disable ignored while in slave mode
// RL7: Software stops slave by read then soft reset
// RL8: Keep-select on select0 with fault detection hangs
// RL9: Software sets mode fault disable with keep-select
// RL10: Disabled unit drops data writes, empty flag stays
// RL11: Software halts DMA before disabling the unit
// RL12: Enabled data write clears empty until loaded
`timescale 1ns/10ps
`default_nettype none
`include "spi_unit_cfg.svh"
module spi_unit (
  input wire logic core_clk,
  input wire logic reset,
  input wire spi_unit_pkg::spi_cfg_t cfg,
  input wire logic enable_cmd,
  input wire logic disable_cmd,
  input wire logic soft_reset_cmd,
  input wire logic tx_write,
  input wire logic [7:0] transmit_data_reg,
  input wire logic rx_read,
  input wire logic sclk_in,
  input wire logic select_n_in,
  input wire logic mosi_in,
  output logic enabled,
  output logic transmit_empty_flag,
  output logic receive_ready_flag,
  output logic [7:0] receive_holding_reg,
  output logic sclk_out,
  output logic sclk_oe_n,
  output logic mosi_out,
  output logic miso_out,
  output logic miso_oe_n,
  output logic select0_n
);
  import spi_unit_pkg::*;
  logic [2:0] sck_s_q, cs_s_q, mosi_s_q;
  logic [2:0] sck_s_d, cs_s_d, mosi_s_d;
  logic en_q, en_d, txe_q, txe_d, rxr_q, rxr_d, tx_full_q, tx_full_d;
  logic [7:0] tx_hold_q, tx_hold_d, shift_q, shift_d, rxh_q, rxh_d;
  logic [7:0] div_cnt_q, div_cnt_d;
  logic [3:0] bit_q, bit_d;
  logic sck_q, sck_d, sel_q, sel_d, prev_sel_q, prev_sel_d, extra_q, extra_d;
  logic miso_q, miso_d, mosi_q, mosi_d;
  logic sclk_oe_n_q, sclk_oe_n_d, miso_oe_n_q, miso_oe_n_d, select0_n_q, select0_n_d;
  mst_state_t st_q, st_d;
  logic sck_rise, sck_fall, cs_low, sample_edge, shift_edge, hang, mixed;
  logic [7:0] cur_div;
  // Synchronisers: select counts once stages two and three agree; data is taken from stage three
  always_comb begin
    sck_s_d = {sck_s_q[1:0], sclk_in};
    cs_s_d = {cs_s_q[1:0], select_n_in};
    mosi_s_d = {mosi_s_q[1:0], mosi_in};
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sck_s_q <= 3'h0;
      cs_s_q <= 3'h7;
      mosi_s_q <= 3'h0;
    end else begin
      sck_s_q <= sck_s_d;
      cs_s_q <= cs_s_d;
      mosi_s_q <= mosi_s_d;
    end
  end
  assign sck_rise = sck_s_q[1] & sck_s_q[2] == 1'b0 & sck_s_q[1];
  assign sck_fall = !sck_s_q[1] & sck_s_q[2];
  assign cs_low = !cs_s_q[1] & !cs_s_q[2];
  assign sample_edge = (cfg.clock_polarity_select ^ cfg.clock_phase_select) ? sck_fall : sck_rise;
  assign shift_edge = (cfg.clock_polarity_select ^ cfg.clock_phase_select) ? sck_rise : sck_fall;
  assign hang = cfg.keep_select_after_transfer0 & !cfg.mode_fault_disable & !cfg.active_select; // RL8
  assign cur_div = cfg.active_select ? cfg.serial_clock_divisor1 : cfg.serial_clock_divisor0;
  assign mixed = (cfg.serial_clock_divisor0 == `DIVISOR_ONE) !=
                 (cfg.serial_clock_divisor1 == `DIVISOR_ONE); // RL2
  always_comb begin
    en_d = en_q;
    txe_d = txe_q;
    rxr_d = rxr_q;
    tx_full_d = tx_full_q;
    tx_hold_d = tx_hold_q;
    shift_d = shift_q;
    rxh_d = rxh_q;
    div_cnt_d = div_cnt_q;
    bit_d = bit_q;
    sck_d = sck_q;
    sel_d = sel_q;
    prev_sel_d = prev_sel_q;
    extra_d = 1'b0;
    miso_d = miso_q;
    mosi_d = mosi_q;
    st_d = st_q;
    if (enable_cmd && !en_q) begin
      en_d = 1'b1;
      if (!cfg.master_mode) begin
        rxr_d = 1'b1; // RL4
      end
    end
    if (disable_cmd && cfg.master_mode) begin
      en_d = 1'b0; // RL6
    end
    if (rx_read) begin
      rxr_d = 1'b0;
    end
    if (en_q && !cfg.master_mode) begin
      // No underrun detection: a missed load sends stale data silently
      if (!cs_low) begin
        bit_d = 4'h0;
        // First bit must stand before the first sampling edge
        miso_d = shift_q[7];
        if (tx_full_q) begin
          shift_d = tx_hold_q; // RL1
          miso_d = tx_hold_q[7];
          tx_full_d = 1'b0;
          txe_d = 1'b1;
        end
      end else if (sample_edge) begin
        shift_d = {shift_q[6:0], mosi_s_q[2]};
        bit_d = bit_q + 4'h1;
        if (bit_q == 4'h7) begin
          rxh_d = {shift_q[6:0], mosi_s_q[2]};
          rxr_d = 1'b1;
          bit_d = 4'h0;
          if (tx_full_q) begin
            shift_d = tx_hold_q; // RL1
            tx_full_d = 1'b0;
            txe_d = 1'b1;
          end
        end
      end else if (shift_edge) begin
        miso_d = shift_q[7];
      end
    end
    if (en_q && cfg.master_mode) begin
      case (st_q)
        ST_IDLE: begin
          sck_d = cfg.clock_polarity_select;
          if (tx_full_q && !hang) begin // RL8
            shift_d = tx_hold_q;
            tx_full_d = 1'b0;
            txe_d = 1'b1;
            bit_d = 4'h0;
            div_cnt_d = 8'h00;
            sel_d = 1'b1;
            mosi_d = tx_hold_q[7];
            extra_d = mixed & cfg.clock_polarity_select & !cfg.clock_phase_select &
                      (prev_sel_q != cfg.active_select); // RL2
            prev_sel_d = cfg.active_select;
            st_d = ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (extra_q) begin
            sck_d = !sck_q; // RL2
            // Stay set for the return edge so the stray pulse is whole
            extra_d = sck_q == cfg.clock_polarity_select;
          end else if (div_cnt_q + 8'h01 >= cur_div) begin
            div_cnt_d = 8'h00;
            sck_d = !sck_q;
            if (sck_q == cfg.clock_polarity_select) begin
              shift_d = {shift_q[6:0], mosi_s_q[2]};
            end else begin
              mosi_d = shift_q[7];
              bit_d = bit_q + 4'h1;
              if (bit_q == 4'h7) begin
                st_d = ST_DONE;
              end
            end
          end else begin
            div_cnt_d = div_cnt_q + 8'h01;
          end
        end
        ST_DONE: begin
          rxh_d = shift_q;
          rxr_d = 1'b1;
          sel_d = cfg.keep_select_after_transfer0 & !cfg.active_select;
          st_d = ST_IDLE;
        end
        default: st_d = ST_IDLE;
      endcase
    end
    // Disabled unit: writes are dropped and the empty flag is left alone
    // A write in a load cycle still wins, so back-to-back words are kept
    if (tx_write && en_q) begin // RL10
      tx_hold_d = transmit_data_reg;
      tx_full_d = 1'b1;
      txe_d = 1'b0; // RL12
    end
    if (soft_reset_cmd) begin
      en_d = 1'b0; // RL7
      st_d = ST_IDLE;
      tx_full_d = 1'b0;
      txe_d = 1'b1;
      rxr_d = 1'b0;
      sel_d = 1'b0;
    end
    sclk_oe_n_d = !(en_d & cfg.master_mode);
    miso_oe_n_d = !(en_d & !cfg.master_mode & cs_low);
    select0_n_d = !(sel_d & !cfg.active_select);
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      en_q <= 1'b0;
      txe_q <= `TX_EMPTY_RESET;
      rxr_q <= 1'b0;
      tx_full_q <= 1'b0;
      tx_hold_q <= 8'h00;
      shift_q <= 8'h00;
      rxh_q <= 8'h00;
      div_cnt_q <= 8'h00;
      bit_q <= 4'h0;
      sck_q <= `SCLK_IDLE_RESET;
      sel_q <= 1'b0;
      prev_sel_q <= 1'b0;
      extra_q <= 1'b0;
      sclk_oe_n_q <= 1'b1;
      miso_oe_n_q <= 1'b1;
      select0_n_q <= 1'b1;
      miso_q <= 1'b0;
      mosi_q <= 1'b0;
      st_q <= ST_IDLE;
    end else begin
      en_q <= en_d;
      txe_q <= txe_d;
      rxr_q <= rxr_d;
      tx_full_q <= tx_full_d;
      tx_hold_q <= tx_hold_d;
      shift_q <= shift_d;
      rxh_q <= rxh_d;
      div_cnt_q <= div_cnt_d;
      bit_q <= bit_d;
      sck_q <= sck_d;
      sel_q <= sel_d;
      prev_sel_q <= prev_sel_d;
      extra_q <= extra_d;
      sclk_oe_n_q <= sclk_oe_n_d;
      miso_oe_n_q <= miso_oe_n_d;
      select0_n_q <= select0_n_d;
      miso_q <= miso_d;
      mosi_q <= mosi_d;
      st_q <= st_d;
    end
  end
  always_comb begin
    enabled = en_q;
    transmit_empty_flag = txe_q;
    receive_ready_flag = rxr_q;
    receive_holding_reg = rxh_q;
    sclk_out = sck_q;
    sclk_oe_n = sclk_oe_n_q;
    mosi_out = mosi_q;
    miso_out = miso_q;
    miso_oe_n = miso_oe_n_q;
    select0_n = select0_n_q;
  end
  slave_disable_a: assert property (@(posedge core_clk) disable iff (reset) // RL6
    en_q && !cfg.master_mode && disable_cmd && !soft_reset_cmd |=> en_q)
    else $error("slave disable took effect");
  dropped_write_a: assert property (@(posedge core_clk) disable iff (reset) // RL10
    !en_q && tx_write && !soft_reset_cmd |=> $stable(txe_q))
    else $error("write while disabled changed empty flag");
  write_clears_a: assert property (@(posedge core_clk) disable iff (reset) // RL12
    en_q && tx_write && !soft_reset_cmd |=> !txe_q && tx_full_q)
    else $error("enabled write did not clear empty flag");
  hang_start_a: assert property (@(posedge core_clk) disable iff (reset) // RL8
    st_q == ST_IDLE && hang |=> st_q == ST_IDLE)
    else $error("transfer started under keep-select hang");
  false_ready_a: assert property (@(posedge core_clk) disable iff (reset) // RL4
    !en_q && enable_cmd && !cfg.master_mode && !soft_reset_cmd |=> rxr_q)
    else $error("slave enable did not raise ready");
  sequence sclk_idle_s;
    sck_q == cfg.clock_polarity_select;
  endsequence
  sequence sclk_away_s;
    sck_q != cfg.clock_polarity_select;
  endsequence
  extra_pulse_a: assert property (@(posedge core_clk) disable iff (reset) // RL2
    $rose(extra_q) |-> sclk_idle_s ##1 sclk_away_s ##1 sclk_idle_s)
    else $error("extra clock pulse missing");
  slave_load_a: assert property (@(posedge core_clk) disable iff (reset) // RL1
    en_q && !cfg.master_mode && !cs_low && tx_full_q && !soft_reset_cmd && !tx_write
    |=> txe_q && shift_q == $past(tx_hold_q))
    else $error("slave load missed");
endmodule
`default_nettype wire

// *** spi_peer_model.sv ***
// External serial master that drives the unit's slave-side pins
`timescale 1ns/10ps
`default_nettype none
module spi_peer_model (
  output logic sclk,
  output logic select_n,
  output logic mosi
);
  initial begin
    sclk = 1'b0;
    select_n = 1'b1;
    mosi = 1'b0;
  end
  // Mode 0 frame, MSB first; the clock stands still low outside frames
  task automatic send_byte(input logic [7:0] data);
    select_n = 1'b0;
    #62.5;
    for (int i = 7; i >= 0; i--) begin
      mosi = data[i];
      #62.5;
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
    end
    #62.5;
    select_n = 1'b1;
    // A released line must not keep looking valid
    mosi = ~mosi;
  endtask
endmodule
`default_nettype wire

// *** tb_spi_master_slave_errata_behaviour.sv ***
// Self-checking bench for the serial peripheral unit
`timescale 1ns/10ps
`default_nettype none
module tb_spi_master_slave_errata_behaviour;
  import spi_unit_pkg::*;
  logic core_clk, reset, enable_cmd, disable_cmd, soft_reset_cmd, tx_write, rx_read;
  logic [7:0] tx_data, receive_holding_reg;
  logic sclk_in, select_n_in, mosi_in, enabled, transmit_empty_flag, receive_ready_flag;
  logic sclk_out, sclk_oe_n, mosi_out, miso_out, miso_oe_n, select0_n;
  spi_cfg_t cfg;
  int failures = 0;
  int checks = 0;
  int pulses = 0;
  int pulse_base;
  logic [7:0] mosi_cap, miso_cap;

  spi_unit i_spi_unit (
    .core_clk(core_clk), .reset(reset), .cfg(cfg), .enable_cmd(enable_cmd),
    .disable_cmd(disable_cmd), .soft_reset_cmd(soft_reset_cmd), .tx_write(tx_write),
    .transmit_data_reg(tx_data), .rx_read(rx_read), .sclk_in(sclk_in),
    .select_n_in(select_n_in), .mosi_in(mosi_in), .enabled(enabled),
    .transmit_empty_flag(transmit_empty_flag), .receive_ready_flag(receive_ready_flag),
    .receive_holding_reg(receive_holding_reg), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .mosi_out(mosi_out), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .select0_n(select0_n)
  );
  spi_peer_model i_spi_peer_model (.sclk(sclk_in), .select_n(select_n_in), .mosi(mosi_in));

  // Data as the far side samples it, and clock pulses away from idle
  always @(posedge sclk_out) mosi_cap <= {mosi_cap[6:0], mosi_out};
  always @(posedge sclk_in) miso_cap <= {miso_cap[6:0], miso_out};
  always @(sclk_out) if (sclk_out !== cfg.clock_polarity_select) pulses <= pulses + 1;

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic check_bit(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask
  task automatic wait_ready(input int n);
    for (int i = 0; i < n && receive_ready_flag !== 1'b1; i++) cyc(1);
  endtask
  task automatic summarize();
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #100us;
    failures++;
    $display("FAIL at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    reset = 1'b1;
    {enable_cmd, disable_cmd, soft_reset_cmd, tx_write, rx_read} = 5'h00;
    cfg = '0;
    tx_data = 8'h3C;
    repeat (20) @(posedge core_clk);
    #1;
    reset = 1'b0;
    cyc(1);
    check_bit(transmit_empty_flag, 1'b1);
    check_bit(receive_ready_flag, 1'b0);
    check_bit(select0_n, 1'b1);
    cfg.master_mode = 1'b1;
    cfg.serial_clock_divisor0 = 8'h02;
    cfg.serial_clock_divisor1 = 8'h02;
    pulse(tx_write);
    cyc(2);
    check_bit(transmit_empty_flag, 1'b1);
    pulse(enable_cmd);
    check_bit(enabled, 1'b1);
    check_bit(sclk_oe_n, 1'b0);
    pulse(tx_write);
    check_bit(transmit_empty_flag, 1'b0);
    wait_ready(100);
    check_bit(receive_ready_flag, 1'b1);
    check_bit(transmit_empty_flag, 1'b1);
    check(mosi_cap, 8'h3C);
    pulse(rx_read);
    check_bit(receive_ready_flag, 1'b0);
    // Held select on select0 with fault detection on: the word must wait
    cfg.keep_select_after_transfer0 = 1'b1;
    tx_data = 8'h96;
    pulse(tx_write);
    cyc(100);
    check_bit(receive_ready_flag, 1'b0);
    cfg.mode_fault_disable = 1'b1;
    wait_ready(100);
    check_bit(receive_ready_flag, 1'b1);
    check(mosi_cap, 8'h96);
    check_bit(select0_n, 1'b0);
    pulse(rx_read);
    // Mixed divisors, polarity one, phase zero and a select change: one stray pulse
    cfg.keep_select_after_transfer0 = 1'b0;
    cfg.clock_polarity_select = 1'b1;
    cfg.serial_clock_divisor0 = 8'h01;
    cfg.active_select = 1'b1;
    pulse_base = pulses;
    pulse(tx_write);
    wait_ready(100);
    check(8'(pulses - pulse_base), 8'h09);
    pulse(rx_read);
    // Every divisor at one keeps the pulse count right
    cfg.serial_clock_divisor1 = 8'h01;
    cfg.active_select = 1'b0;
    pulse_base = pulses;
    pulse(tx_write);
    wait_ready(100);
    check(8'(pulses - pulse_base), 8'h08);
    check_bit(select0_n, 1'b1);
    pulse(rx_read);
    // No further data writes once the stream is stopped, then disable
    pulse(disable_cmd);
    check_bit(enabled, 1'b0);
    cfg.master_mode = 1'b0;
    cfg.clock_polarity_select = 1'b0;
    pulse(enable_cmd);
    cyc(3);
    check_bit(sclk_oe_n, 1'b1);
    check_bit(receive_ready_flag, 1'b1);
    cfg.clock_polarity_select = 1'b1;
    cyc(4);
    cfg.clock_polarity_select = 1'b0;
    cyc(4);
    pulse(rx_read);
    check_bit(receive_ready_flag, 1'b0);
    pulse(disable_cmd);
    check_bit(enabled, 1'b1);
    check_bit(miso_oe_n, 1'b1);
    tx_data = 8'h5A;
    pulse(tx_write);
    cyc(2);
    check_bit(transmit_empty_flag, 1'b1);
    // One word queued; a missed reload after it would go unreported
    i_spi_peer_model.send_byte(8'hA5);
    cyc(1);
    wait_ready(50);
    check_bit(receive_ready_flag, 1'b1);
    check(receive_holding_reg, 8'hA5);
    check(miso_cap, 8'h5A);
    check_bit(enabled, 1'b1);
    pulse(rx_read);
    pulse(soft_reset_cmd);
    check_bit(enabled, 1'b0);
    check_bit(receive_ready_flag, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
